// *** inc/dcr_pkg.sv ***
// Constants and carrier types of the memory-access channel
package dcr_pkg;
    // Register decode uses word-address bits only
    localparam int IDX_W = 6;
    localparam int ADDR_LSB = 2;

    // Register indices; byte address is four times the index
    localparam logic [31:0] IDX_CH1_INDEX = 32'h5000361E;
    localparam logic [31:0] IDX_SRC_LO = 32'h50003620;
    localparam logic [31:0] IDX_SRC_HI = 32'h50003622;
    localparam logic [31:0] IDX_DST_LO = 32'h50003624;
    localparam logic [31:0] IDX_DST_HI = 32'h50003626;
    localparam logic [31:0] IDX_THRESH = 32'h50003628;
    localparam logic [31:0] IDX_LEN = 32'h5000362A;
    localparam logic [31:0] IDX_CTRL = 32'h5000362C;
    localparam logic [31:0] IDX_CH2_INDEX = 32'h5000362E;

    localparam logic [IDX_W-1:0] KEY_CH1_INDEX = IDX_CH1_INDEX[IDX_W-1:0];
    localparam logic [IDX_W-1:0] KEY_SRC_LO = IDX_SRC_LO[IDX_W-1:0];
    localparam logic [IDX_W-1:0] KEY_SRC_HI = IDX_SRC_HI[IDX_W-1:0];
    localparam logic [IDX_W-1:0] KEY_DST_LO = IDX_DST_LO[IDX_W-1:0];
    localparam logic [IDX_W-1:0] KEY_DST_HI = IDX_DST_HI[IDX_W-1:0];
    localparam logic [IDX_W-1:0] KEY_THRESH = IDX_THRESH[IDX_W-1:0];
    localparam logic [IDX_W-1:0] KEY_LEN = IDX_LEN[IDX_W-1:0];
    localparam logic [IDX_W-1:0] KEY_CTRL = IDX_CTRL[IDX_W-1:0];
    localparam logic [IDX_W-1:0] KEY_CH2_INDEX = IDX_CH2_INDEX[IDX_W-1:0];

    // Control register fields
    localparam int C_ON = 0;
    localparam int C_BW_LO = 1;
    localparam int C_BW_HI = 2;
    localparam int C_IRQ_EN = 3;
    localparam int C_PERIPH = 4;
    localparam int C_DINC = 5;
    localparam int C_SINC = 6;
    localparam int C_CIRC = 7;
    localparam int C_IDLE = 11;
    localparam int C_FILL = 12;
    localparam int C_EDGE = 13;
    localparam logic [15:0] CTRL_WMASK = 16'h3FFF;
    localparam logic [15:0] REG_RESET = 16'h0000;

    // Item width codes and address steps
    localparam logic [1:0] BW_BYTE = 2'h0;
    localparam logic [1:0] BW_HALF = 2'h1;
    localparam logic [1:0] BW_WORD = 2'h2;
    localparam logic [1:0] BW_RSVD = 2'h3;
    localparam logic [31:0] STEP_BYTE = 32'h00000001;
    localparam logic [31:0] STEP_HALF = 32'h00000002;
    localparam logic [31:0] STEP_WORD = 32'h00000004;

    localparam int HTRANS_ACTIVE = 1;
    localparam logic HRESP_OKAY = 1'b0;

    typedef enum logic [1:0] {DCR_IDLE, DCR_READ, DCR_WRITE, DCR_GAP} dcr_state_e;

    // System bus request from the channel; held until ready while ce is high, cleared while ce is low
    typedef struct packed {
        logic valid;
        logic write;
        logic [31:0] addr;
        logic [1:0] size;
        logic [31:0] wdata;
    } dcr_mreq_s;

    typedef struct packed {
        logic ready;
        logic [31:0] rdata;
    } dcr_mrsp_s;
endpackage

// *** logic/dcr_req_sense.sv ***
// Peripheral request sensing: level or latched rising edge
`timescale 1ns/1ns
`default_nettype none
module dcr_req_sense (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic edge_mode,
    input wire logic req,
    input wire logic take,
    output logic avail
);
    typedef struct packed {
        logic prev;
        logic pend;
    } dcr_sense_s;

    dcr_sense_s r;
    dcr_sense_s next_r;

    always_comb begin
        next_r = r;
        if (ce) begin
            next_r.prev = req;
            // A new edge in the take cycle survives
            next_r.pend = (r.pend && !take) || (req && !r.prev);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign avail = edge_mode ? r.pend : req;
endmodule
`default_nettype wire

// *** logic/dcr_channel.sv ***
// Memory-access channel: register slave, item engine and request pacing
`timescale 1ns/1ns
`default_nettype none
module dcr_channel (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [15:0] ch1_item_index,
    input wire logic periph_req,
    output var dcr_pkg::dcr_mreq_s mreq,
    input wire dcr_pkg::dcr_mrsp_s mrsp,
    output logic bus_lock,
    output logic irq
);
    localparam int IW = dcr_pkg::IDX_W;
    localparam int AL = dcr_pkg::ADDR_LSB;

    typedef struct packed {
        logic [15:0] src_lo;
        logic [15:0] src_hi;
        logic [15:0] dst_lo;
        logic [15:0] dst_hi;
        logic [15:0] thresh;
        logic [15:0] len;
        logic [15:0] ctrl;
        logic [15:0] idx;
        dcr_pkg::dcr_state_e st;
        logic [31:0] data;
        logic ph_valid;
        logic ph_write;
        logic [IW-1:0] ph_idx;
        logic [31:0] rdata;
        logic irq;
    } dcr_regs_s;

    dcr_regs_s r;
    dcr_regs_s next_r;

    logic on;
    logic fill;
    logic periph;
    logic idle_bit;
    logic circ;
    logic irq_en;
    logic sinc;
    logic dinc;
    logic [1:0] bw;
    logic req_avail;
    logic take;
    logic item_done;
    logic sw_write;
    logic addr_hit;

    assign on = r.ctrl[dcr_pkg::C_ON];
    assign fill = r.ctrl[dcr_pkg::C_FILL];
    assign periph = r.ctrl[dcr_pkg::C_PERIPH];
    assign idle_bit = r.ctrl[dcr_pkg::C_IDLE];
    assign circ = r.ctrl[dcr_pkg::C_CIRC];
    assign irq_en = r.ctrl[dcr_pkg::C_IRQ_EN];
    assign sinc = r.ctrl[dcr_pkg::C_SINC];
    assign dinc = r.ctrl[dcr_pkg::C_DINC];
    assign bw = r.ctrl[dcr_pkg::C_BW_HI:dcr_pkg::C_BW_LO];
    assign sw_write = r.ph_valid && r.ph_write;
    assign addr_hit = hsel && htrans[dcr_pkg::HTRANS_ACTIVE];

    // Reserved width code falls back to bytes
    function automatic logic [1:0] item_shift(input logic [1:0] code);
        return (code == dcr_pkg::BW_RSVD) ? dcr_pkg::BW_BYTE : code;
    endfunction

    function automatic logic [31:0] item_addr(
        input logic [31:0] base,
        input logic inc,
        input logic [1:0] code,
        input logic [15:0] index
    );
        logic [31:0] off;
        off = {16'h0000, index} << item_shift(code);
        return inc ? base + off : base;
    endfunction

    function automatic logic [15:0] reg_read(input dcr_regs_s s, input logic [IW-1:0] key);
        logic [15:0] v;
        v = dcr_pkg::REG_RESET;
        case (key)
            dcr_pkg::KEY_CH1_INDEX: v = ch1_item_index;
            dcr_pkg::KEY_SRC_LO: v = s.src_lo;
            dcr_pkg::KEY_SRC_HI: v = s.src_hi;
            dcr_pkg::KEY_DST_LO: v = s.dst_lo;
            dcr_pkg::KEY_DST_HI: v = s.dst_hi;
            dcr_pkg::KEY_THRESH: v = s.thresh;
            dcr_pkg::KEY_LEN: v = s.len;
            dcr_pkg::KEY_CTRL: v = s.ctrl;
            dcr_pkg::KEY_CH2_INDEX: v = s.idx;
            default: v = dcr_pkg::REG_RESET;
        endcase
        return v;
    endfunction

    function automatic dcr_regs_s reg_write(
        input dcr_regs_s s,
        input logic [IW-1:0] key,
        input logic [15:0] v
    );
        dcr_regs_s t;
        t = s;
        // Index registers are read-only; writes there are dropped
        case (key)
            dcr_pkg::KEY_SRC_LO: t.src_lo = v;
            dcr_pkg::KEY_SRC_HI: t.src_hi = v;
            dcr_pkg::KEY_DST_LO: t.dst_lo = v;
            dcr_pkg::KEY_DST_HI: t.dst_hi = v;
            dcr_pkg::KEY_THRESH: t.thresh = v;
            dcr_pkg::KEY_LEN: t.len = v;
            dcr_pkg::KEY_CTRL: t.ctrl = v & dcr_pkg::CTRL_WMASK;
            default: t = s;
        endcase
        return t;
    endfunction

    dcr_req_sense u_sense (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .edge_mode(r.ctrl[dcr_pkg::C_EDGE]),
        .req(periph_req),
        .take(take),
        .avail(req_avail)
    );

    always_comb begin
        next_r = r;
        mreq = '0;
        take = 1'b0;
        item_done = 1'b0;
        if (ce) begin
            next_r.irq = 1'b0;
            unique case (r.st)
                dcr_pkg::DCR_IDLE: begin
                    if (on && (!periph || req_avail)) begin
                        take = periph;
                        // Fill fetches the source only for the first item
                        if (fill && r.idx != '0) begin
                            next_r.st = dcr_pkg::DCR_WRITE;
                        end else begin
                            next_r.st = dcr_pkg::DCR_READ;
                        end
                    end
                end
                dcr_pkg::DCR_READ: begin
                    mreq.valid = 1'b1;
                    mreq.size = item_shift(bw);
                    mreq.addr = item_addr({r.src_hi, r.src_lo}, sinc && !fill, bw, r.idx);
                    if (mrsp.ready) begin
                        next_r.data = mrsp.rdata;
                        next_r.st = dcr_pkg::DCR_WRITE;
                    end
                end
                dcr_pkg::DCR_WRITE: begin
                    mreq.valid = 1'b1;
                    mreq.write = 1'b1;
                    mreq.size = item_shift(bw);
                    mreq.wdata = r.data;
                    mreq.addr = item_addr({r.dst_hi, r.dst_lo}, dinc, bw, r.idx);
                    item_done = mrsp.ready;
                end
                dcr_pkg::DCR_GAP: begin
                    next_r.st = dcr_pkg::DCR_IDLE;
                end
            endcase

            if (item_done) begin
                // Compared before the index moves on
                next_r.irq = irq_en && (r.thresh == r.idx);
                if (r.idx == r.len) begin
                    next_r.idx = '0;
                    if (!(circ && periph)) begin
                        next_r.ctrl[dcr_pkg::C_ON] = 1'b0;
                    end
                end else begin
                    next_r.idx = r.idx + 16'h0001;
                end
                // Paced transfers already leave gaps between requests
                if (idle_bit && !periph) begin
                    next_r.st = dcr_pkg::DCR_GAP;
                end else begin
                    next_r.st = dcr_pkg::DCR_IDLE;
                end
            end

            // Software write lands after the engine, so it wins
            if (sw_write) begin
                next_r = reg_write(next_r, r.ph_idx, hwdata[15:0]);
            end

            if (hready) begin
                next_r.ph_valid = addr_hit;
                next_r.ph_write = hwrite;
                next_r.ph_idx = haddr[IW+AL-1:AL];
                // Read sees a write from the data phase just ending
                if (addr_hit && !hwrite) begin
                    next_r.rdata = {16'h0000, reg_read(next_r, haddr[IW+AL-1:AL])};
                end
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // Stalling the bus while frozen keeps accesses from being lost
    assign hreadyout = ce;
    assign hresp = dcr_pkg::HRESP_OKAY;
    assign hrdata = r.rdata;
    assign irq = r.irq;
    // Fill never yields; blocking mode holds the bus between items
    assign bus_lock = on && (fill || (!periph && !idle_bit));

    // Checks beside the logic they guard
    default clocking dcr_cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    logic [31:0] dst_step;
    assign dst_step = (bw == dcr_pkg::BW_WORD) ? dcr_pkg::STEP_WORD :
                      (bw == dcr_pkg::BW_HALF) ? dcr_pkg::STEP_HALF : dcr_pkg::STEP_BYTE;

    sequence s_last_item;
        ce && item_done && (r.idx == r.len);
    endsequence

    sequence s_mid_item;
        ce && item_done && (r.idx != r.len);
    endsequence

    sequence s_gap_then_idle;
        (r.st == dcr_pkg::DCR_GAP) ##1 (r.st inside {dcr_pkg::DCR_GAP, dcr_pkg::DCR_IDLE});
    endsequence

    idx_clear_a: assert property (s_last_item |=> (r.idx == '0))
        else $error("index not cleared after last item");

    idx_step_a: assert property (s_mid_item |=> (r.idx == $past(r.idx) + 16'h0001))
        else $error("index did not step by one");

    dst_addr_a: assert property (mreq.valid && mreq.write && dinc |->
        (mreq.addr == {r.dst_hi, r.dst_lo} + {16'h0000, r.idx} * dst_step))
        else $error("destination address wrong for index and width");

    fill_once_a: assert property (fill && (r.idx != '0) && on |->
        (r.st != dcr_pkg::DCR_READ))
        else $error("fill mode fetched the source again");

    irq_cause_a: assert property ($rose(r.irq) |->
        ($past(r.thresh) == $past(r.idx)) && $past(irq_en))
        else $error("interrupt without enabled threshold match");

    irq_pulse_a: assert property (r.irq && ce |=> !r.irq)
        else $error("interrupt longer than one cycle");

    on_clear_a: assert property (s_last_item and (!(circ && periph) && !sw_write) |=>
        !on)
        else $error("enable not cleared after normal transfer");

    circ_keep_a: assert property (s_last_item and (circ && periph && !sw_write) |=>
        on && (r.idx == '0))
        else $error("circular transfer did not restart");

    idle_gap_a: assert property (ce && item_done && idle_bit && !periph |=>
        s_gap_then_idle)
        else $error("no idle cycle after store");

    paced_gap_a: assert property (ce && item_done && periph |=>
        (r.st == dcr_pkg::DCR_IDLE))
        else $error("paced transfer inserted an idle cycle");

    req_wait_a: assert property (ce && on && periph && !req_avail &&
        (r.st == dcr_pkg::DCR_IDLE) |=> (r.st == dcr_pkg::DCR_IDLE))
        else $error("item started without a request");

    fill_lock_a: assert property (on && fill && (r.st != dcr_pkg::DCR_IDLE) |-> bus_lock)
        else $error("bus released during fill");

    block_lock_a: assert property (s_mid_item and (!idle_bit && !periph && !sw_write) |=>
        bus_lock [*2])
        else $error("blocking transfer released the bus");

    irq_match_a: assert property (ce && item_done && irq_en && (r.thresh == r.idx) |=>
        r.irq)
        else $error("threshold match gave no interrupt");

    irq_mask_a: assert property (ce && item_done && !irq_en |=> !r.irq)
        else $error("interrupt raised while disabled");

    // Same item step as the destination check; width code alone decides it
    src_addr_a: assert property (mreq.valid && !mreq.write && sinc && !fill |->
        (mreq.addr == {r.src_hi, r.src_lo} + {16'h0000, r.idx} * dst_step))
        else $error("source address wrong for index and width");

    src_fixed_a: assert property (mreq.valid && !mreq.write && (fill || !sinc) |->
        (mreq.addr == {r.src_hi, r.src_lo}))
        else $error("fixed source address moved");

    item_size_a: assert property (mreq.valid |->
        ((dcr_pkg::STEP_BYTE << mreq.size) == dst_step))
        else $error("bus size does not match item width");

    lock_off_a: assert property (!on |-> !bus_lock)
        else $error("bus locked while channel off");
endmodule
`default_nettype wire

// *** sim/dcr_mem_model.sv ***
// Behavioural memory answering the channel's system bus requests
`timescale 1ns/1ns
`default_nettype none
module dcr_mem_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire dcr_pkg::dcr_mreq_s mreq,
    input wire logic [3:0] delay,
    output var dcr_pkg::dcr_mrsp_s mrsp
);
    logic [3:0] waited = 4'h0;
    logic [31:0] last = 32'h0;
    logic ready;
    logic [31:0] wr_addr[$];
    logic [31:0] wr_data[$];
    int reads = 0;
    function automatic logic [31:0] content(input logic [31:0] a);
        return {a[15:0] ^ 16'hA5A5, a[31:16]};
    endfunction
    // Slow answers hold the request; an idle data bus never repeats a value
    assign ready = mreq.valid === 1'b1 && waited == delay;
    assign mrsp = '{ready: ready, rdata: (ready && !mreq.write) ? content(mreq.addr) : ~last};
    always @(posedge hclk) begin
        last <= mrsp.rdata;
        if (ready || !hresetn) begin
            waited <= 4'h0;
        end else if (mreq.valid === 1'b1) begin
            waited <= waited + 4'h1;
        end
        if (ready && hresetn && mreq.write) begin
            wr_addr.push_back(mreq.addr);
            wr_data.push_back(mreq.wdata);
        end else if (ready && hresetn) begin
            reads++;
        end
    end
endmodule
`default_nettype wire

// *** sim/dcr_channel_tb.sv ***
// Self-checking bench for the memory-access channel
`timescale 1ns/1ns
`default_nettype none
module dcr_channel_tb;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic periph_req = 1'b0;
    logic ce = 1'b1;
    logic unlocked = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic [3:0] delay = 4'h0;
    logic [31:0] hrdata;
    logic hready, hreadyout, hresp, bus_lock, irq;
    dcr_pkg::dcr_mreq_s mreq;
    dcr_pkg::dcr_mrsp_s mrsp;
    int fails = 0;
    int total_checks = 0;
    int irqs = 0;
    int idle_run = 0;
    int gap = 0;
    assign hready = hreadyout;
    always #20 hclk = ~hclk;
    dcr_channel i_dut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ch1_item_index(16'h5A3C),
        .periph_req(periph_req), .mreq(mreq), .mrsp(mrsp), .bus_lock(bus_lock), .irq(irq));
    dcr_mem_model i_mem (.hclk(hclk), .hresetn(hresetn), .mreq(mreq), .delay(delay), .mrsp(mrsp));
    // Idle cycles before each request, lock seen while requesting, irq cycles
    always @(posedge hclk) begin
        if (irq === 1'b1) irqs++;
        if (mreq.valid === 1'b1) begin
            if (idle_run > 0) gap = idle_run;
            idle_run = 0;
            if (bus_lock !== 1'b1) unlocked = 1'b1;
        end else begin
            idle_run++;
        end
    end
    task automatic complete_run();
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic edge_ready();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 64);
        if (n >= 64) begin
            fails++;
            complete_run();
        end
    endtask
    // Registers sit one per word: byte address is four times the index
    task automatic bus(input logic w, input logic [31:0] idx, input logic [15:0] wd,
                       output logic [31:0] rd);
        haddr <= idx << 2;
        hwrite <= w;
        htrans <= 2'h2;
        hsel <= 1'b1;
        edge_ready();
        htrans <= 2'h0;
        hwdata <= {16'h0, wd};
        edge_ready();
        rd = hrdata;
        chk("hresp", 32'(dcr_pkg::HRESP_OKAY), 32'(hresp));
    endtask
    task automatic wr(input logic [31:0] idx, input logic [15:0] wd);
        logic [31:0] r;
        bus(1'b1, idx, wd, r);
    endtask
    task automatic rd(input logic [31:0] idx, input logic [15:0] exp, input string name);
        logic [31:0] r;
        bus(1'b0, idx, 16'h0, r);
        chk(name, {16'h0, exp}, r);
    endtask
    task automatic xfer(input logic [15:0] ctrl, input logic [15:0] len, input logic [15:0] thr,
                        input logic [3:0] dly);
        logic [31:0] src, dst, r, m, sa;
        int w, n, i0, r0, q0;
        src = 32'h10000130;
        dst = 32'h20000240;
        w = int'(ctrl[2:1]);
        // Reserved width code moves bytes
        if (w == 3) w = 0;
        m = (w == 0) ? 32'hFF : (w == 1) ? 32'hFFFF : 32'hFFFFFFFF;
        i0 = i_mem.wr_addr.size();
        r0 = i_mem.reads;
        q0 = irqs;
        delay <= dly;
        wr(dcr_pkg::IDX_SRC_LO, src[15:0]);
        wr(dcr_pkg::IDX_SRC_HI, src[31:16]);
        wr(dcr_pkg::IDX_DST_LO, dst[15:0]);
        wr(dcr_pkg::IDX_DST_HI, dst[31:16]);
        wr(dcr_pkg::IDX_LEN, len);
        wr(dcr_pkg::IDX_THRESH, thr);
        unlocked = 1'b0;
        wr(dcr_pkg::IDX_CTRL, ctrl | 16'h1);
        n = 0;
        do begin
            bus(1'b0, dcr_pkg::IDX_CTRL, 16'h0, r);
            n++;
        end while (r[0] !== 1'b0 && n < 100);
        // Let a last-item interrupt pulse be counted before comparing
        repeat (2) @(posedge hclk);
        chk("on cleared", 32'h0, {31'h0, r[0]});
        chk("items", 32'(len) + 1, 32'(i_mem.wr_addr.size() - i0));
        chk("reads", ctrl[12] ? 1 : 32'(len) + 1, 32'(i_mem.reads - r0));
        for (int k = 0; k < int'(len) + 1 && i0 + k < i_mem.wr_addr.size(); k++) begin
            sa = src + ((ctrl[6] && !ctrl[12]) ? 32'(k << w) : 32'h0);
            chk("dst addr", dst + (ctrl[5] ? 32'(k << w) : 32'h0), i_mem.wr_addr[i0 + k]);
            chk("data", i_mem.content(sa) & m, i_mem.wr_data[i0 + k] & m);
        end
        chk("irq count", (ctrl[3] && thr <= len) ? 1 : 0, 32'(irqs - q0));
        rd(dcr_pkg::IDX_CH2_INDEX, 16'h0, "index end");
        chk("gap", (ctrl[11] && !ctrl[4]) ? 2 : 1, 32'(gap));
        chk("lock", (ctrl[12] || !ctrl[11]) ? 0 : 1, {31'h0, unlocked});
    endtask
    initial begin
        logic [31:0] rw[6];
        int i0;
        rw = '{dcr_pkg::IDX_SRC_LO, dcr_pkg::IDX_SRC_HI, dcr_pkg::IDX_DST_LO,
               dcr_pkg::IDX_DST_HI, dcr_pkg::IDX_THRESH, dcr_pkg::IDX_LEN};
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        foreach (rw[i]) rd(rw[i], 16'h0, "reset value");
        rd(dcr_pkg::IDX_CTRL, 16'h0, "reset ctrl");
        rd(dcr_pkg::IDX_CH2_INDEX, 16'h0, "reset index");
        rd(dcr_pkg::IDX_CH1_INDEX, 16'h5A3C, "ch1 index");
        foreach (rw[i]) wr(rw[i], 16'hC3A0 + 16'(i));
        foreach (rw[i]) rd(rw[i], 16'hC3A0 + 16'(i), "readback");
        wr(dcr_pkg::IDX_CTRL, 16'hFFFE);
        rd(dcr_pkg::IDX_CTRL, 16'h3FFE, "ctrl fields");
        wr(dcr_pkg::IDX_CTRL, 16'h0);
        wr(dcr_pkg::IDX_CH1_INDEX, 16'hFFFF);
        wr(dcr_pkg::IDX_CH2_INDEX, 16'hFFFF);
        wr(32'h50003630, 16'hFFFF);
        rd(dcr_pkg::IDX_CH1_INDEX, 16'h5A3C, "ro ch1");
        rd(dcr_pkg::IDX_CH2_INDEX, 16'h0, "ro ch2");
        rd(32'h50003630, 16'h0, "unmapped");
        // Fill runs keep request pacing off and destination increment on
        xfer(16'h006C, 16'h3, 16'h2, 4'h0);
        xfer(16'h106A, 16'h2, 16'h0, 4'h2);
        xfer(16'h0840, 16'h1, 16'h1, 4'h1);
        xfer(16'h0066, 16'h1, 16'h0, 4'h0);
        periph_req <= 1'b1;
        xfer(16'h087C, 16'h2, 16'h5, 4'h0);
        periph_req <= 1'b0;
        i0 = i_mem.wr_addr.size();
        wr(dcr_pkg::IDX_LEN, 16'h1);
        wr(dcr_pkg::IDX_CTRL, 16'h20B1);
        repeat (20) @(posedge hclk);
        chk("no start", 32'(i0), 32'(i_mem.wr_addr.size()));
        // Long high pulses: edge sensing must give one item each
        repeat (3) begin
            periph_req <= 1'b1;
            repeat (12) @(posedge hclk);
            periph_req <= 1'b0;
            repeat (12) @(posedge hclk);
        end
        chk("edge items", 32'(i0 + 3), 32'(i_mem.wr_addr.size()));
        // A request pulse while frozen must leave no pending edge behind
        ce <= 1'b0;
        periph_req <= 1'b1;
        repeat (12) @(posedge hclk);
        periph_req <= 1'b0;
        repeat (12) @(posedge hclk);
        ce <= 1'b1;
        repeat (12) @(posedge hclk);
        chk("frozen items", 32'(i0 + 3), 32'(i_mem.wr_addr.size()));
        rd(dcr_pkg::IDX_CTRL, 16'h20B1, "circular on");
        rd(dcr_pkg::IDX_CH2_INDEX, 16'h1, "circular index");
        wr(dcr_pkg::IDX_CTRL, 16'h0);
        complete_run();
    end
endmodule
`default_nettype wire
